//--- verilog/cpu_regs.sv
// processor register set: instruction pointer, status word,
// stack pointer, general registers and sfr access decode
// assumes single-cycle synchronous memory: read data one cycle
// after o_mem_rd; execution logic waits while o_busy is high
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// Operation
// - pointer advances by instruction byte length
// - branch loads immediate or register pair
// - reset loads pointer from vector bytes
// - vector low byte even, high odd
// - status pushed and restored on stack
// - status word resets to 02h
// - interrupts refused while enable clear
// - enabled: per-source mask decides acceptance
// - enable cleared on disable/acknowledge, set enable
// - zero flag follows result equals zero
// - half carry from bit three
// - carry holds overflow, shift-out, bit accumulator
// - stack lives only in high-speed ram
// - decrement before push, increment after pop
// - only ten stack pointer bits settable
// - out-of-ram stack values fold into ram
// - ram window fe80h through feffh
// - eight byte registers, four pairs
// - pair n is bytes 2n, 2n+1
// - ff00h..ffffh decodes as sfr space
// - sfr access in bit, byte, word units
// - bit access by address and position
module cpu_regs
  import cpu_regs_pkg::*;
(
  input  wire logic         i_mclk,
  input  wire logic         i_rst_b,
  input  wire logic [7:0]   i_reg_addr,
  input  wire logic [7:0]   i_reg_wdata,
  input  wire logic         i_reg_wr,
  input  wire logic         i_reg_rd,
  output logic      [7:0]   o_reg_rdata,
  input  wire logic         i_seq_adv,
  input  wire logic [1:0]   i_insn_len,
  input  wire logic         i_branch,
  input  wire logic         i_branch_from_reg,
  input  wire logic [15:0]  i_branch_imm,
  input  wire logic         i_flag_we,
  input  wire logic [7:0]   i_alu_a,
  input  wire logic [7:0]   i_alu_b,
  input  wire logic [7:0]   i_alu_res,
  input  wire logic         i_cy_we,
  input  wire logic         i_cy_val,
  input  wire logic         i_irq_disable,
  input  wire logic         i_irq_enable,
  input  wire logic [3:0]   i_irq_req,
  input  wire logic [3:0]   i_irq_mask,
  input  wire logic         i_irq_take,
  input  wire logic         i_push_status,
  input  wire logic         i_pop_status,
  input  wire logic         i_return_from_interrupt,
  input  wire logic         i_gpr_we_byte,
  input  wire logic         i_gpr_we_pair,
  input  wire logic [2:0]   i_gpr_wr_idx,
  input  wire logic [15:0]  i_gpr_wr_data,
  input  wire logic [2:0]   i_gpr_rd_byte_idx,
  input  wire logic [1:0]   i_gpr_rd_pair_idx,
  output logic      [7:0]   o_gpr_rd_byte,
  output logic      [15:0]  o_gpr_rd_pair,
  input  wire logic [15:0]  i_sfr_addr,
  input  wire sfr_unit_type i_sfr_unit,
  input  wire logic [2:0]   i_sfr_bit,
  output logic              o_sfr_hit,
  output logic              o_sfr_word_odd,
  output logic      [15:0]  o_sfr_lo_addr,
  output logic      [15:0]  o_sfr_hi_addr,
  output logic      [7:0]   o_sfr_bit_mask,
  output logic      [15:0]  o_mem_addr,
  output logic              o_mem_rd,
  output logic              o_mem_wr,
  output logic      [7:0]   o_mem_wdata,
  input  wire logic [7:0]   i_mem_rdata,
  output logic      [15:0]  o_instruction_pointer,
  output logic      [7:0]   o_processor_status_word,
  output logic      [15:0]  o_stack_top_pointer,
  output logic              o_irq_grant,
  output logic              o_busy
);
  stack_state_type      state_reg;
  stack_state_type      state_next;
  logic [15:0]          pc_reg;
  logic [15:0]          pc_next;
  logic [7:0]           psw_reg;
  logic [7:0]           psw_next;
  logic [SP_BITS-1:0]   sp_reg;
  logic [SP_BITS-1:0]   sp_next;
  logic [7:0]           lo_byte_reg;
  logic                 frame_full_reg;
  logic [7:0]           rdata_reg;
  logic [7:0]           rdata_next;

  // bus decode
  wire bus_wr_psw   = i_reg_wr && (i_reg_addr == OFS_PSW);
  wire bus_wr_sp_lo = i_reg_wr && (i_reg_addr == OFS_SP_LO);
  wire bus_wr_sp_hi = i_reg_wr && (i_reg_addr == OFS_SP_HI);

  wire [15:0] sp_full = {SP_FIXED_TOP, sp_reg};
  wire [15:0] sp_dec  = sp_full - 16'h0001;
  wire [15:0] sp_inc  = sp_full + 16'h0001;
  wire [15:0] push_addr;
  wire [15:0] pop_addr;

  stack_addr_fold u_fold_push (
    .i_addr (sp_dec),
    .o_addr (push_addr)
  );

  stack_addr_fold u_fold_pop (
    .i_addr (sp_full),
    .o_addr (pop_addr)
  );

  gpr_bank u_gpr (
    .i_mclk        (i_mclk),
    .i_rst_b       (i_rst_b),
    .i_we_byte     (i_gpr_we_byte),
    .i_we_pair     (i_gpr_we_pair),
    .i_wr_idx      (i_gpr_wr_idx),
    .i_wr_data     (i_gpr_wr_data),
    .i_rd_byte_idx (i_gpr_rd_byte_idx),
    .i_rd_pair_idx (i_gpr_rd_pair_idx),
    .o_rd_byte     (o_gpr_rd_byte),
    .o_rd_pair     (o_gpr_rd_pair)
  );

  wire idle = (state_reg == ST_IDLE);

  wire irq_pending = |(i_irq_req & ~i_irq_mask);
  assign o_irq_grant = idle && psw_reg[PSW_IE_BIT] && irq_pending;

  wire zero_res = (i_alu_res == 8'h00);
  // carry or borrow across bit 3
  wire half_cy  = i_alu_a[4] ^ i_alu_b[4] ^ i_alu_res[4];

  wire [15:0] br_target = i_branch_from_reg ? o_gpr_rd_pair
                                            : i_branch_imm;
  wire [15:0] pc_seq = pc_reg + {14'h0000, i_insn_len};

  assign o_sfr_hit      = (i_sfr_addr[15:8] == SFR_PAGE);
  assign o_sfr_word_odd = (i_sfr_unit == UNIT_WORD) && i_sfr_addr[0];
  // word splits into even then odd byte
  assign o_sfr_lo_addr  = (i_sfr_unit == UNIT_WORD)
                          ? {i_sfr_addr[15:1], 1'b0} : i_sfr_addr;
  assign o_sfr_hi_addr  = {i_sfr_addr[15:1], 1'b1};
  assign o_sfr_bit_mask = (i_sfr_unit == UNIT_BIT)
                          ? (8'h01 << i_sfr_bit) : 8'hFF;

  // state sequencing of vector fetch and stack frames
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_VEC_LO:    state_next = ST_VEC_HI;
      ST_VEC_HI:    state_next = ST_VEC_END;
      ST_VEC_END:   state_next = ST_IDLE;
      ST_IDLE:
      begin
        if (i_irq_take || i_push_status)
          state_next = ST_PUSH_PSW;
        else if (i_return_from_interrupt)
          state_next = ST_POP_PCL;
        else if (i_pop_status)
          state_next = ST_POP_ONLY;
      end
      ST_PUSH_PSW:  state_next = frame_full_reg ? ST_PUSH_PCH
                                                : ST_IDLE;
      ST_PUSH_PCH:  state_next = ST_PUSH_PCL;
      ST_PUSH_PCL:  state_next = ST_IDLE;
      ST_POP_PCL:   state_next = ST_POP_PCH;
      ST_POP_PCH:   state_next = ST_POP_PSWRD;
      ST_POP_PSWRD: state_next = ST_POP_END;
      ST_POP_ONLY:  state_next = ST_POP_END;
      ST_POP_END:   state_next = ST_IDLE;
    endcase
  end

  // memory port
  // vector reads at reset
  // status word and return pointer to and from stack
  always_comb
  begin
    o_mem_addr  = 16'h0000;
    o_mem_rd    = 1'b0;
    o_mem_wr    = 1'b0;
    o_mem_wdata = 8'h00;
    unique case (state_reg)
      ST_VEC_LO:
      begin
        o_mem_addr = VEC_LO_ADDR;
        o_mem_rd   = 1'b1;
      end
      ST_VEC_HI:
      begin
        o_mem_addr = VEC_HI_ADDR;
        o_mem_rd   = 1'b1;
      end
      ST_PUSH_PSW:
      begin
        o_mem_addr  = push_addr;
        o_mem_wr    = 1'b1;
        o_mem_wdata = psw_reg;
      end
      ST_PUSH_PCH:
      begin
        o_mem_addr  = push_addr;
        o_mem_wr    = 1'b1;
        o_mem_wdata = pc_reg[15:8];
      end
      ST_PUSH_PCL:
      begin
        o_mem_addr  = push_addr;
        o_mem_wr    = 1'b1;
        o_mem_wdata = pc_reg[7:0];
      end
      ST_POP_PCL, ST_POP_PCH, ST_POP_PSWRD, ST_POP_ONLY:
      begin
        o_mem_addr = pop_addr;
        o_mem_rd   = 1'b1;
      end
      default:
      begin
        o_mem_addr = 16'h0000;
      end
    endcase
  end

  // pre-decrement on push, post-increment on pop
  wire st_push = (state_reg == ST_PUSH_PSW) ||
                 (state_reg == ST_PUSH_PCH) ||
                 (state_reg == ST_PUSH_PCL);
  wire st_pop  = (state_reg == ST_POP_PCL) ||
                 (state_reg == ST_POP_PCH) ||
                 (state_reg == ST_POP_PSWRD) ||
                 (state_reg == ST_POP_ONLY);

  // only ten bits stored; the stack address fold keeps the stack in ram
  always_comb
  begin
    sp_next = sp_reg;
    if (bus_wr_sp_lo)
      sp_next = {sp_reg[SP_BITS-1:8], i_reg_wdata};
    if (bus_wr_sp_hi)
      sp_next = {i_reg_wdata[SP_BITS-9:0], sp_reg[7:0]};
    if (st_push)
      sp_next = sp_dec[SP_BITS-1:0];
    if (st_pop)
      sp_next = sp_inc[SP_BITS-1:0];
  end

  always_comb
  begin
    pc_next = pc_reg;
    if (idle && i_branch)
      pc_next = br_target;
    else if (idle && i_seq_adv)
      pc_next = pc_seq;
    if ((state_reg == ST_VEC_END) || (state_reg == ST_POP_PSWRD))
      pc_next = {i_mem_rdata, lo_byte_reg};
  end

  always_comb
  begin
    psw_next = psw_reg;
    if (bus_wr_psw)
      psw_next = i_reg_wdata;
    if (i_flag_we)
    begin
      psw_next[PSW_Z_BIT]  = zero_res;
      psw_next[PSW_AC_BIT] = half_cy;
    end
    if (i_cy_we)
      psw_next[PSW_CY_BIT] = i_cy_val;
    if (state_reg == ST_POP_END)
      psw_next = i_mem_rdata;
    if (i_irq_disable || (idle && i_irq_take))
      psw_next[PSW_IE_BIT] = 1'b0;
    else if (i_irq_enable)
      psw_next[PSW_IE_BIT] = 1'b1;
  end

  wire [7:0] sp_hi_rd = sp_full[15:8];
  always_comb
  begin
    rdata_next = READ_UNMAPPED;
    if (i_reg_rd)
    begin
      unique case (i_reg_addr)
        OFS_PSW:   rdata_next = psw_reg;
        OFS_SP_LO: rdata_next = sp_full[7:0];
        OFS_SP_HI: rdata_next = sp_hi_rd;
        OFS_PC_LO: rdata_next = pc_reg[7:0];
        OFS_PC_HI: rdata_next = pc_reg[15:8];
        default:   rdata_next = READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_reg <= ST_VEC_LO;
      pc_reg    <= 16'h0000;
      psw_reg   <= PSW_RESET;
      sp_reg    <= '0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      pc_reg    <= pc_next;
      psw_reg   <= psw_next;
      sp_reg    <= sp_next;
      rdata_reg <= rdata_next;
    end
  end

  // captured low byte and frame kind
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      lo_byte_reg    <= 8'h00;
      frame_full_reg <= 1'b0;
    end
    else
    begin
      if ((state_reg == ST_VEC_HI) || (state_reg == ST_POP_PCH))
        lo_byte_reg <= i_mem_rdata;
      if (idle)
        frame_full_reg <= i_irq_take;
    end
  end

  assign o_reg_rdata             = rdata_reg;
  assign o_instruction_pointer   = pc_reg;
  assign o_processor_status_word = psw_reg;
  assign o_stack_top_pointer     = sp_full;
  assign o_busy                  = !idle;
endmodule // cpu_regs

//--- verilog/cpu_regs_pkg.sv
// constants, offsets and types of the processor register set
// shared by the register set top and its two helper modules
package cpu_regs_pkg;
  // reset vector bytes: low byte at the even location
  localparam logic [15:0] VEC_LO_ADDR   = 16'h0000;
  localparam logic [15:0] VEC_HI_ADDR   = 16'h0001;
  localparam logic [7:0]  PSW_RESET     = 8'h02;
  // status word bit positions
  localparam int          PSW_IE_BIT    = 7;
  localparam int          PSW_Z_BIT     = 6;
  localparam int          PSW_AC_BIT    = 4;
  localparam int          PSW_CY_BIT    = 0;
  // stack pointer: ten settable bits, fixed upper bits
  localparam int          SP_BITS       = 10;
  localparam logic [5:0]  SP_FIXED_TOP  = 6'h3E;
  // high-speed ram fe80h..feffh: upper nine address bits
  localparam logic [8:0]  RAM_TOP9      = 9'h1FD;
  // special-function register page ff00h..ffffh
  localparam logic [7:0]  SFR_PAGE      = 8'hFF;
  // software register port offsets
  localparam logic [7:0]  OFS_PSW       = 8'h00;
  localparam logic [7:0]  OFS_SP_LO     = 8'h01;
  localparam logic [7:0]  OFS_SP_HI     = 8'h02;
  localparam logic [7:0]  OFS_PC_LO     = 8'h03;
  localparam logic [7:0]  OFS_PC_HI     = 8'h04;
  localparam logic [7:0]  READ_UNMAPPED = 8'h00;

  typedef enum logic [1:0] {
    UNIT_BIT,
    UNIT_BYTE,
    UNIT_WORD
  } sfr_unit_type;

  typedef enum logic [3:0] {
    ST_VEC_LO,
    ST_VEC_HI,
    ST_VEC_END,
    ST_IDLE,
    ST_PUSH_PSW,
    ST_PUSH_PCH,
    ST_PUSH_PCL,
    ST_POP_PCL,
    ST_POP_PCH,
    ST_POP_PSWRD,
    ST_POP_ONLY,
    ST_POP_END
  } stack_state_type;
endpackage

//--- verilog/stack_addr_fold.sv
// folds a stack address into the high-speed ram window
// purely combinational; used for every stack access address
`timescale 1ns/1ps
module stack_addr_fold
  import cpu_regs_pkg::*;
(
  input  wire logic [15:0] i_addr,
  output logic      [15:0] o_addr
);
  // keep low seven bits in ram
  assign o_addr = {RAM_TOP9, i_addr[6:0]};
endmodule // stack_addr_fold

//--- verilog/gpr_bank.sv
// eight byte registers, paired into four 16-bit registers
// written by the execution logic on the core clock
`timescale 1ns/1ps
module gpr_bank
  import cpu_regs_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  input  wire logic        i_we_byte,
  input  wire logic        i_we_pair,
  input  wire logic [2:0]  i_wr_idx,
  input  wire logic [15:0] i_wr_data,
  input  wire logic [2:0]  i_rd_byte_idx,
  input  wire logic [1:0]  i_rd_pair_idx,
  output logic      [7:0]  o_rd_byte,
  output logic      [15:0] o_rd_pair
);
  logic [7:0] bank_reg [8];
  wire  [2:0] pair_lo_idx = {i_wr_idx[1:0], 1'b0};
  wire  [2:0] pair_hi_idx = {i_wr_idx[1:0], 1'b1};
  wire  [2:0] rd_lo_idx   = {i_rd_pair_idx, 1'b0};
  wire  [2:0] rd_hi_idx   = {i_rd_pair_idx, 1'b1};

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      for (int k = 0; k < 8; k++)
        bank_reg[k] <= 8'h00;
    end
    else if (i_we_pair)
    begin
      bank_reg[pair_lo_idx] <= i_wr_data[7:0];
      bank_reg[pair_hi_idx] <= i_wr_data[15:8];
    end
    else if (i_we_byte)
      bank_reg[i_wr_idx] <= i_wr_data[7:0];
  end

  assign o_rd_byte = bank_reg[i_rd_byte_idx];
  // pair n, bytes 2n and 2n+1
  assign o_rd_pair = {bank_reg[rd_hi_idx], bank_reg[rd_lo_idx]};
endmodule // gpr_bank

//--- bench/cpu_regs_sva.sv
// assertions on the register set top ports
// bound into cpu_regs; one clock, asynchronous active-low reset
`timescale 1ns/1ps
module cpu_regs_sva
  import cpu_regs_pkg::*;
(
  input wire logic         i_mclk,
  input wire logic         i_rst_b,
  input wire logic         i_seq_adv,
  input wire logic [1:0]   i_insn_len,
  input wire logic         i_branch,
  input wire logic         i_flag_we,
  input wire logic [7:0]   i_alu_res,
  input wire logic         i_irq_take,
  input wire logic [3:0]   i_irq_req,
  input wire logic [3:0]   i_irq_mask,
  input wire logic [15:0]  i_sfr_addr,
  input wire sfr_unit_type i_sfr_unit,
  input wire logic [2:0]   i_sfr_bit,
  input wire logic         o_sfr_hit,
  input wire logic [7:0]   o_sfr_bit_mask,
  input wire logic [15:0]  o_sfr_lo_addr,
  input wire logic [15:0]  o_sfr_hi_addr,
  input wire logic [15:0]  o_mem_addr,
  input wire logic         o_mem_wr,
  input wire logic [7:0]   o_mem_wdata,
  input wire logic [15:0]  o_instruction_pointer,
  input wire logic [7:0]   o_processor_status_word,
  input wire logic [15:0]  o_stack_top_pointer,
  input wire logic         o_irq_grant,
  input wire logic         o_busy
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  // status word, then return pointer high and low, then idle
  sequence s_frame;
    o_mem_wr && !o_mem_wdata[PSW_IE_BIT] && o_mem_addr[15:7] == RAM_TOP9
    ##1 o_mem_wr && o_mem_wdata == o_instruction_pointer[15:8]
    ##1 o_mem_wr && o_mem_wdata == o_instruction_pointer[7:0]
    ##1 !o_busy;
  endsequence

  AST_SEQ_ADVANCE: assert property (
    !o_busy && i_seq_adv && !i_branch |=>
    o_instruction_pointer == $past(o_instruction_pointer) + 16'($past(i_insn_len)))
    else $error("pointer did not advance by length");
  AST_GRANT_GATE: assert property (
    o_irq_grant == (o_processor_status_word[PSW_IE_BIT] && !o_busy
                    && |(i_irq_req & ~i_irq_mask)))
    else $error("grant disagrees with enable and masks");
  AST_TAKE_CLEARS_IE: assert property (
    !o_busy && i_irq_take |=> !o_processor_status_word[PSW_IE_BIT])
    else $error("enable flag not cleared on take");
  AST_ZERO_FLAG: assert property (
    i_flag_we && !o_busy |=>
    o_processor_status_word[PSW_Z_BIT] == ($past(i_alu_res) == 8'h00))
    else $error("zero flag wrong");
  AST_STACK_TOP_BITS: assert property (
    o_stack_top_pointer[15:10] == SP_FIXED_TOP)
    else $error("stack pointer upper bits wrong");
  AST_STACK_IN_RAM: assert property (
    o_mem_wr |-> o_mem_addr[15:7] == RAM_TOP9)
    else $error("stack write outside ram");
  AST_IRQ_FRAME: assert property (
    !o_busy && i_irq_take |=> s_frame)
    else $error("interrupt frame wrong");
  AST_SFR_DECODE: assert property (
    o_sfr_hit == (i_sfr_addr[15:8] == SFR_PAGE))
    else $error("sfr decode wrong");
  AST_BIT_MASK: assert property (
    i_sfr_unit == UNIT_BIT |-> o_sfr_bit_mask == 8'h01 << i_sfr_bit)
    else $error("bit mask wrong");
  AST_WORD_SPLIT: assert property (
    i_sfr_unit == UNIT_WORD |->
    o_sfr_lo_addr == {i_sfr_addr[15:1], 1'b0} && o_sfr_hi_addr == (i_sfr_addr | 16'h0001))
    else $error("word split wrong");
endmodule // cpu_regs_sva

bind cpu_regs cpu_regs_sva cpu_regs_sva_inst (.*);

//--- bench/testbench.sv
// self-checking bench for the processor register set
// drives every port itself and models memory as a byte array
`timescale 1ns/1ps
module testbench;
  import cpu_regs_pkg::*;
  localparam int ADV = 0, BR = 1, FLG = 2, CYW = 3, DIS = 4, ENA = 5;
  localparam int TAKE = 6, PUSH = 7, POP = 8, RTN = 9, WB = 10, WP = 11;
  logic        i_mclk, i_rst_b, i_reg_wr, i_reg_rd;
  logic [1:0]  i_gpr_rd_pair_idx;
  logic [2:0]  i_gpr_rd_byte_idx, i_sfr_bit;
  logic [3:0]  i_irq_req, i_irq_mask;
  logic [7:0]  i_reg_addr, i_reg_wdata, i_mem_rdata;
  logic [15:0] i_sfr_addr;
  logic [11:0] ctl;
  logic [23:0] dat;
  sfr_unit_type i_sfr_unit;
  wire         i_seq_adv, i_branch, i_flag_we, i_cy_we, i_irq_disable, i_irq_enable;
  wire         i_irq_take, i_push_status, i_pop_status, i_return_from_interrupt, i_gpr_we_byte;
  wire         i_gpr_we_pair, i_branch_from_reg, i_cy_val;
  wire [1:0]   i_insn_len;
  wire [2:0]   i_gpr_wr_idx;
  wire [7:0]   i_alu_a, i_alu_b, i_alu_res;
  wire [15:0]  i_branch_imm, i_gpr_wr_data;
  logic [7:0]  o_reg_rdata, o_gpr_rd_byte, o_sfr_bit_mask, o_mem_wdata;
  logic [7:0]  o_processor_status_word;
  logic [15:0] o_gpr_rd_pair, o_sfr_lo_addr, o_sfr_hi_addr, o_mem_addr;
  logic [15:0] o_instruction_pointer, o_stack_top_pointer;
  logic        o_sfr_hit, o_sfr_word_odd, o_mem_rd, o_mem_wr, o_irq_grant, o_busy;
  logic [7:0]  mem [0:65535];
  int          n_errors, n_tests;

  assign {i_gpr_we_pair, i_gpr_we_byte, i_return_from_interrupt, i_pop_status, i_push_status, i_irq_take,
          i_irq_enable, i_irq_disable, i_cy_we, i_flag_we, i_branch, i_seq_adv} = ctl;
  assign {i_alu_a, i_alu_b, i_alu_res} = dat;
  assign i_branch_imm = dat[15:0];
  assign i_gpr_wr_data = dat[15:0];
  assign i_gpr_wr_idx = dat[18:16];
  assign i_insn_len = dat[1:0];
  assign i_cy_val = dat[0];
  assign i_branch_from_reg = dat[23];

  cpu_regs cpu_regs_inst (.*);

  // memory answers one cycle after a read; otherwise the bus toggles
  always @(posedge i_mclk)
  begin
    if (o_mem_wr) mem[o_mem_addr] <= o_mem_wdata;
    i_mem_rdata <= o_mem_rd ? mem[o_mem_addr] : ~i_mem_rdata;
  end

  initial
  begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pulse(input int k, input logic [23:0] d = 24'h0);
    @(posedge i_mclk);
    ctl <= 12'(1) << k;
    dat <= d;
    @(posedge i_mclk);
    ctl <= '0;
    @(negedge i_mclk);
  endtask

  task automatic wait_idle;
    repeat (10)
      if (o_busy) @(negedge i_mclk);
    chk(o_busy, 0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_mclk);
    i_reg_rd <= 1'b0;
    @(negedge i_mclk);
    chk(o_reg_rdata, e);
  endtask

  task automatic t_boot;
    wait_idle;
    chk(o_instruction_pointer, 16'h1234);
    rd(OFS_PSW, 8'h02);
    $display("boot done");
  endtask

  task automatic t_regs;
    wr(OFS_SP_LO, 8'h00);
    wr(OFS_SP_HI, 8'hFF);
    rd(OFS_SP_HI, 8'hFB);
    chk(o_stack_top_pointer, 16'hFB00);
    wr(OFS_PC_LO, 8'h00);
    rd(OFS_PC_LO, 8'h34);
    rd(OFS_PC_HI, 8'h12);
    rd(8'h07, READ_UNMAPPED);
    $display("register port done");
  endtask

  task automatic t_ptr;
    logic [15:0] e;
    e = 16'h1234;
    for (int n = 1; n < 4; n++)
    begin
      pulse(ADV, 24'(n));
      e = e + 16'(n);
      chk(o_instruction_pointer, e);
    end
    pulse(BR, 24'h00A5C3);
    chk(o_instruction_pointer, 16'hA5C3);
    $display("pointer done");
  endtask

  task automatic t_gpr;
    for (int i = 0; i < 8; i++)
      pulse(WB, 24'((i << 16) | (8'h10 + i)));
    for (int n = 0; n < 4; n++)
    begin
      @(posedge i_mclk);
      i_gpr_rd_pair_idx <= 2'(n);
      i_gpr_rd_byte_idx <= 3'(2 * n + 1);
      @(negedge i_mclk);
      chk(o_gpr_rd_pair, {8'(8'h11 + 2 * n), 8'(8'h10 + 2 * n)});
      chk(o_gpr_rd_byte, 8'(8'h11 + 2 * n));
    end
    pulse(WP, 24'h03BEEF);
    chk(o_gpr_rd_byte, 8'hBE);
    pulse(BR, 24'h800000);
    chk(o_instruction_pointer, 16'hBEEF);
    $display("general registers done");
  endtask

  task automatic t_flags;
    pulse(FLG, 24'h0F0110);
    chk(o_processor_status_word, 8'h12);
    pulse(FLG, 24'h808000);
    chk(o_processor_status_word, 8'h42);
    pulse(CYW, 24'h000001);
    chk(o_processor_status_word, 8'h43);
    $display("flags done");
  endtask

  task automatic t_irq;
    @(posedge i_mclk);
    i_irq_req <= 4'h1;
    @(negedge i_mclk);
    chk(o_irq_grant, 0);
    pulse(ENA);
    chk(o_irq_grant, 1);
    @(posedge i_mclk);
    i_irq_mask <= 4'h1;
    @(negedge i_mclk);
    chk(o_irq_grant, 0);
    @(posedge i_mclk);
    i_irq_mask <= 4'h0;
    pulse(DIS);
    chk(o_irq_grant, 0);
    pulse(ENA);
    pulse(TAKE);
    chk(o_processor_status_word, 8'h43);
    wait_idle;
    chk(o_stack_top_pointer, 16'hFAFD);
    chk({mem[16'hFEFF], mem[16'hFEFE], mem[16'hFEFD]}, 24'h43BEEF);
    pulse(CYW);
    pulse(BR);
    pulse(RTN);
    wait_idle;
    chk(o_instruction_pointer, 16'hBEEF);
    chk(o_processor_status_word, 8'h43);
    chk(o_stack_top_pointer, 16'hFB00);
    $display("interrupt frame done");
  endtask

  task automatic t_push;
    pulse(CYW);
    pulse(PUSH);
    wait_idle;
    chk(o_stack_top_pointer, 16'hFAFF);
    chk(mem[16'hFEFF], 8'h42);
    pulse(CYW, 24'h000001);
    pulse(POP);
    wait_idle;
    chk(o_processor_status_word, 8'h42);
    chk(o_stack_top_pointer, 16'hFB00);
    $display("status push done");
  endtask

  task automatic t_sfr;
    for (int u = 0; u < 3; u++)
    begin
      @(posedge i_mclk);
      i_sfr_addr <= 16'hFF07;
      i_sfr_unit <= sfr_unit_type'(u);
      i_sfr_bit <= 3'h5;
      @(negedge i_mclk);
      chk(o_sfr_hit, 1);
      chk(o_sfr_bit_mask, u == 0 ? 8'h20 : 8'hFF);
      chk(o_sfr_word_odd, u == 2);
      chk(o_sfr_lo_addr, u == 2 ? 16'hFF06 : 16'hFF07);
      chk(o_sfr_hi_addr, 16'hFF07);
    end
    @(posedge i_mclk);
    i_sfr_addr <= 16'hFE07;
    @(negedge i_mclk);
    chk(o_sfr_hit, 0);
    $display("sfr decode done");
  endtask

  task print_verdict;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    {i_rst_b, i_reg_wr, i_reg_rd, ctl, dat, i_irq_req, i_irq_mask} = '0;
    {i_reg_addr, i_reg_wdata, i_sfr_addr, i_sfr_bit} = '0;
    {i_gpr_rd_pair_idx, i_gpr_rd_byte_idx} = '0;
    i_sfr_unit = UNIT_BYTE;
    mem[0] = 8'h34;
    mem[1] = 8'h12;
    repeat (20) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    t_boot;
    t_regs;
    t_ptr;
    t_gpr;
    t_flags;
    t_irq;
    t_push;
    t_sfr;
    print_verdict;
  end

  initial
  begin
    repeat (5000) @(posedge i_mclk);
    n_errors++;
    print_verdict;
  end
endmodule // testbench
